// ===== cmd_pkg.sv
// Constants shared by the LIN master end and the LED driver command end.
// Assumes both ends run on one clock and exchange whole frames as bytes.
package cmd_pkg;
	// ==========================================================
	// Frame identifiers and byte values
	localparam logic [7:0] ID_OTP_WRITE = 8'he7;
	localparam logic [7:0] ID_MASTER_REQ = 8'h3c;
	localparam logic [7:0] SLEEP_FIRST = 8'h00;
	localparam logic [7:0] FILL_BYTE = 8'hff;
	localparam logic [1:0] NODE_LEAD = 2'b11;
	localparam logic [3:0] PTR_LEAD = 4'hf;
	// ==========================================================
	// Frame lengths in data bytes
	localparam logic [3:0] OTP_LEN = 4'h4;
	localparam logic [3:0] SLEEP_LEN = 4'h8;
	localparam logic [3:0] MAX_LEN = 4'h8;
	// ==========================================================
	// Byte positions inside the data field, and the NODE_RESET node value
	localparam logic [3:0] POS_NODE = 4'h0;
	localparam logic [3:0] POS_PTR = 4'h2;
	localparam logic [3:0] POS_VAL = 4'h3;
	localparam logic [5:0] NODE_RESET = 6'h00;

	// Classic checksum step: add with end-around carry.
	function automatic logic [7:0] csum_add(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		csum_add = s[7:0] + {7'h00, s[8]};
	endfunction
endpackage

// ===== lin_frame_if.sv
// Interface carrying LIN frames from master to slave as a byte stream.
// Assumes a shared clock; each byte is a one-cycle strobe.
`timescale 1ns/10ps
interface lin_frame_if;
	logic start;
	logic [7:0] byte_data;
	logic byte_valid;
	logic frame_end;
	modport master (output start, output byte_data, output byte_valid,
		output frame_end);
	modport slave (input start, input byte_data, input byte_valid,
		input frame_end);
endinterface

// ===== lin_cmd_slave.sv
// LED driver end: decodes OTP byte writes and the broadcast sleep frame.
// Assumes frames arrive as: start with identifier, data bytes, then
// the checksum byte marked by frame_end.
// Behaviour
// [R01] One valid addressed command writes one byte.
// [R02] Pointer in low nibble, upper nibble ones.
// [R03] Fourth data byte is stored whole.
// [R04] Master sends ones in pointer nibble, byte two.
// [R05] Master sends sleep with identifier 0x3C.
// [R06] First byte 0x00 means go to sleep.
// [R07] Master sends bytes two to eight as 0xFF.
// [R08] Sleep applies regardless of node address.
// [R09] OTP write needs matching node field.
// [R10] Bad checksum discards the frame.
`timescale 1ns/10ps
module lin_cmd_slave (
	input wire logic clk,
	input wire logic rst,
	lin_frame_if.slave bus,
	input wire logic [5:0] node_addr,
	output logic otp_we,
	output logic [3:0] otp_addr,
	output logic [7:0] otp_data,
	output logic sleep_req,
	output logic frame_err
);
	typedef enum logic [2:0] {
		IDLE = 3'b001,
		DATA = 3'b010,
		DONE = 3'b100
	} state_type;
	localparam logic [2:0] NODE_IDX = cmd_pkg::POS_NODE[2:0];
	localparam logic [2:0] PTR_IDX = cmd_pkg::POS_PTR[2:0];
	localparam logic [2:0] VAL_IDX = cmd_pkg::POS_VAL[2:0];
	state_type state_r;
	logic [7:0] id_r;
	logic [3:0] cnt_r;
	logic [7:0] sum_r;
	logic [7:0] buf_r [0:7];
	logic take_byte;
	logic decide;
	logic okay;
	logic is_otp;
	logic is_sleep;
	logic write_ok;
	logic sleep_ok;

	// ==========================================================
	// Helpers
	// Identifier and length must both agree before any byte is trusted.
	function automatic logic frame_is(input logic [7:0] id,
		input logic [3:0] cnt,
		input logic [7:0] want_id,
		input logic [3:0] want_len);
		frame_is = (id == want_id) && (cnt == want_len);
	endfunction

	// ==========================================================
	// Byte strobes
	// The checksum travels with frame_end and is never stored as data.
	assign take_byte = state_r == DATA && bus.byte_valid &&
		!bus.frame_end && !bus.start;
	assign decide = state_r == DATA && bus.frame_end && !bus.start;

	// ==========================================================
	// Frame state
	// A start always restarts capture, so a cut frame is simply dropped.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= IDLE;
		end else if (bus.start) begin
			state_r <= DATA;
		end else begin
			case (state_r)
				IDLE: state_r <= IDLE;
				DATA: begin
					if (bus.frame_end) begin
						state_r <= DONE;
					end
				end
				DONE: state_r <= IDLE;
				default: state_r <= IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			id_r <= 8'h00;
		end else if (bus.start) begin
			id_r <= bus.byte_data;
		end
	end

	// The count stops one past the longest frame, so an overlong frame
	// can never alias back onto a legal length.
	always_ff @(posedge clk) begin
		if (rst || bus.start) begin
			cnt_r <= 4'h0;
		end else if (take_byte && cnt_r <= cmd_pkg::MAX_LEN) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	// The checksum covers data bytes only, so the identifier is left out.
	always_ff @(posedge clk) begin
		if (rst || bus.start) begin
			sum_r <= 8'h00;
		end else if (take_byte && cnt_r < cmd_pkg::MAX_LEN) begin
			sum_r <= cmd_pkg::csum_add(sum_r, bus.byte_data); // R10
		end
	end

	always_ff @(posedge clk) begin
		if (take_byte && cnt_r < cmd_pkg::MAX_LEN) begin
			buf_r[cnt_r[2:0]] <= bus.byte_data;
		end
	end

	// ==========================================================
	// Decode at the checksum byte
	assign okay = (~sum_r) == bus.byte_data; // R10
	assign is_otp = frame_is(id_r, cnt_r, cmd_pkg::ID_OTP_WRITE,
		cmd_pkg::OTP_LEN) &&
		buf_r[NODE_IDX] == {cmd_pkg::NODE_LEAD, node_addr} && // R09
		buf_r[PTR_IDX][7:4] == cmd_pkg::PTR_LEAD; // R02
	// Any node identity is ignored here on purpose.
	assign is_sleep = frame_is(id_r, cnt_r, cmd_pkg::ID_MASTER_REQ,
		cmd_pkg::SLEEP_LEN) &&
		buf_r[NODE_IDX] == cmd_pkg::SLEEP_FIRST; // R06 R08
	assign write_ok = decide && okay && is_otp;
	assign sleep_ok = decide && okay && is_sleep;

	// ==========================================================
	// Outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			otp_we <= 1'b0;
		end else begin
			otp_we <= write_ok; // R01
		end
	end

	// Address and data hold after the pulse for a slow memory port.
	always_ff @(posedge clk) begin
		if (rst) begin
			otp_addr <= 4'h0;
			otp_data <= 8'h00;
		end else if (write_ok) begin
			otp_addr <= buf_r[PTR_IDX][3:0]; // R02
			otp_data <= buf_r[VAL_IDX]; // R03
		end
	end

	// Sleep is sticky: waking belongs to the bus wake-up logic.
	always_ff @(posedge clk) begin
		if (rst) begin
			sleep_req <= 1'b0;
		end else if (sleep_ok) begin
			sleep_req <= 1'b1; // R08
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			frame_err <= 1'b0;
		end else begin
			frame_err <= decide && !okay; // R10
		end
	end
endmodule

// ===== lin_cmd_master.sv
// LIN master end: builds OTP write and sleep frames on command.
// Assumes requests are held off while busy is high.
`timescale 1ns/10ps
module lin_cmd_master (
	input wire logic clk,
	input wire logic rst,
	lin_frame_if.master bus,
	input wire logic send_otp,
	input wire logic send_sleep,
	input wire logic [5:0] node_sel,
	input wire logic [3:0] ptr,
	input wire logic [7:0] value,
	output logic busy
);
	logic [7:0] frm_r [0:7];
	logic [3:0] len_r;
	logic [3:0] idx_r;
	logic [7:0] sum_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			busy <= 1'b0;
			bus.start <= 1'b0;
			bus.byte_valid <= 1'b0;
			bus.frame_end <= 1'b0;
			bus.byte_data <= 8'h00;
			len_r <= 4'h0;
			idx_r <= 4'h0;
			sum_r <= 8'h00;
		end else if (!busy) begin
			bus.byte_valid <= 1'b0;
			bus.frame_end <= 1'b0;
			bus.start <= send_otp || send_sleep;
			busy <= send_otp || send_sleep;
			idx_r <= 4'h0;
			sum_r <= 8'h00;
			if (send_otp) begin
				bus.byte_data <= cmd_pkg::ID_OTP_WRITE;
				len_r <= cmd_pkg::OTP_LEN;
				frm_r[0] <= {cmd_pkg::NODE_LEAD, node_sel};
				frm_r[1] <= cmd_pkg::FILL_BYTE; // R04
				frm_r[2] <= {cmd_pkg::PTR_LEAD, ptr}; // R02 R04
				frm_r[3] <= value; // R03
			end else if (send_sleep) begin
				bus.byte_data <= cmd_pkg::ID_MASTER_REQ; // R05
				len_r <= cmd_pkg::SLEEP_LEN;
				frm_r[0] <= cmd_pkg::SLEEP_FIRST; // R06
				for (int i = 1; i < int'(cmd_pkg::MAX_LEN); i++) begin
					frm_r[3'(i)] <= cmd_pkg::FILL_BYTE; // R07
				end
			end
		end else begin
			bus.start <= 1'b0;
			if (idx_r < len_r) begin
				bus.byte_valid <= 1'b1;
				bus.byte_data <= frm_r[idx_r[2:0]];
				sum_r <= cmd_pkg::csum_add(sum_r, frm_r[idx_r[2:0]]);
				idx_r <= idx_r + 4'h1;
			end else begin
				bus.byte_valid <= 1'b1;
				bus.frame_end <= 1'b1;
				bus.byte_data <= ~sum_r; // R10
				busy <= 1'b0;
			end
		end
	end
endmodule

// ===== lin_link_monitor.sv
// Checker for the frame link between the two ends.
// Assumes one clock; placed beside the interface by the testbench.
`timescale 1ns/10ps
module lin_link_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] byte_data,
	input wire logic byte_valid,
	input wire logic frame_end,
	input wire logic [5:0] node_addr,
	input wire logic otp_we,
	input wire logic [3:0] otp_addr,
	input wire logic [7:0] otp_data,
	input wire logic sleep_req,
	input wire logic frame_err
);
	// ==========================================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_single_write: assert property (otp_we |=> !otp_we)
		else $error("write pulse too long");
	a_otp_layout: assert property (start && byte_data == 8'he7 |->
		##1 byte_data[7:6] == 2'b11 ##1 byte_data == 8'hff
		##1 byte_data[7:4] == 4'hf) else $error("bad write frame");
	a_otp_store: assert property (otp_we |-> $past(frame_end) &&
		otp_data == $past(byte_data, 2) &&
		otp_addr == $past(byte_data[3:0], 3)) else $error("bad write");
	a_node_match: assert property (otp_we |->
		$past(byte_data[5:0], 5) == node_addr) else $error("wrong node");
	a_frame_id: assert property (start |->
		byte_data inside {8'he7, 8'h3c}) else $error("bad identifier");
	a_sleep_first: assert property (start && byte_data == 8'h3c |=>
		byte_valid && byte_data == 8'h00) else $error("bad sleep byte");
	a_sleep_fill: assert property (start && byte_data == 8'h3c |->
		##2 (byte_data == 8'hff) [*7]) else $error("bad sleep fill");
	a_sleep_cause: assert property ($rose(sleep_req) |->
		$past(frame_end)) else $error("sleep without frame");
	a_err_pulse: assert property (frame_err |-> $past(frame_end)
		##1 !frame_err) else $error("bad error pulse");
endmodule

// ===== testbench.sv
// Master and slave joined, plus a second slave fed raw frames.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/10ps
module testbench;
	logic clk = 0, rst = 1, s_otp = 0, s_slp = 0, busy;
	logic [5:0] nsel = 6'h15;
	logic [3:0] ptr = 4'h0, oa, oa2;
	logic [7:0] val = 8'h00, od, od2;
	logic we, slp, err, we2, slp2, err2;
	int miscompares = 0, samples_checked = 0, wc = 0, wc2 = 0, ec2 = 0;
	int ec = 0;
	lin_frame_if lif();
	lin_frame_if raw();
	lin_cmd_master lin_cmd_master_i (.clk, .rst, .bus(lif), .send_otp(s_otp),
		.send_sleep(s_slp), .node_sel(nsel), .ptr(ptr), .value(val),
		.busy(busy));
	lin_cmd_slave lin_cmd_slave_i (.clk, .rst, .bus(lif), .node_addr(6'h15),
		.otp_we(we), .otp_addr(oa), .otp_data(od), .sleep_req(slp),
		.frame_err(err));
	lin_cmd_slave lin_cmd_slave_i2 (.clk, .rst, .bus(raw),
		.node_addr(6'h15), .otp_we(we2), .otp_addr(oa2), .otp_data(od2),
		.sleep_req(slp2), .frame_err(err2));
	lin_link_monitor lin_link_monitor_i (.clk, .rst, .start(lif.start),
		.byte_data(lif.byte_data), .byte_valid(lif.byte_valid),
		.frame_end(lif.frame_end), .node_addr(6'h15), .otp_we(we),
		.otp_addr(oa), .otp_data(od), .sleep_req(slp), .frame_err(err));
	// ==========================================================
	// Clock, counters and tasks
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		wc <= wc + int'(we);
		wc2 <= wc2 + int'(we2);
		ec2 <= ec2 + int'(err2);
		ec <= ec + int'(err);
	end
	task chk(input logic [7:0] g, e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	endtask
	task mst(input logic o);
		@(negedge clk);
		s_otp = o;
		s_slp = !o;
		@(negedge clk);
		s_otp = 0;
		s_slp = 0;
		@(negedge clk);
		for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge clk);
		// The write counter moves one edge after the pulse, so wait two.
		repeat (2) @(negedge clk);
	endtask
	// The checksum is worked out here so a bad one can be forced.
	task frm(input logic [7:0] id, input logic [63:0] d, input int n,
		input logic [7:0] cx);
		logic [8:0] s;
		s = 0;
		@(negedge clk);
		raw.start = 1;
		raw.byte_data = id;
		@(negedge clk);
		raw.start = 0;
		raw.byte_valid = 1;
		for (int i = 0; i < n; i++) begin
			raw.byte_data = d[63 - 8 * i -: 8];
			s = {1'b0, s[7:0]} + {1'b0, raw.byte_data};
			s = {1'b0, s[7:0]} + {8'h00, s[8]};
			@(negedge clk);
		end
		raw.frame_end = 1;
		raw.byte_data = ~s[7:0] ^ cx;
		@(negedge clk);
		raw.frame_end = 0;
		raw.byte_valid = 0;
		repeat (2) @(negedge clk);
	endtask
	task end_sim;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		#10us;
		miscompares++;
		end_sim;
	end
	initial begin
		raw.start = 0;
		raw.byte_valid = 0;
		raw.frame_end = 0;
		raw.byte_data = 8'h00;
		repeat (12) @(negedge clk);
		rst = 0;
		for (int i = 0; i < 3; i++) begin
			ptr = 4'(i * 7);
			val = 8'(i * 127);
			mst(1);
			chk(8'(wc), 8'(i + 1));
			chk(oa, ptr);
			chk(od, val);
		end
		nsel = 6'h2a;
		mst(1);
		chk(8'(wc), 8'h03);
		mst(0);
		chk(slp, 1'b1);
		frm(8'he7, {32'hd5fff3a5, 32'h0}, 4, 8'h01);
		chk(8'(ec2), 8'h01);
		frm(8'he7, {32'hd5ff73a5, 32'h0}, 4, 8'h00);
		chk(8'(wc2), 8'h00);
		frm(8'h3c, {8'h01, {7{8'hff}}}, 8, 8'h00);
		chk(slp2, 1'b0);
		frm(8'h3c, {8'h00, {7{8'hff}}}, 8, 8'h01);
		chk(slp2, 1'b0);
		frm(8'he7, {32'hd5fff3a5, 32'h0}, 4, 8'h00);
		chk(od2, 8'ha5);
		chk(8'(oa2), 8'h03);
		chk(8'(wc2), 8'h01);
		frm(8'h3c, {8'h00, {7{8'hff}}}, 8, 8'h00);
		chk(slp2, 1'b1);
		chk(8'(ec), 8'h00);
		end_sim;
	end
endmodule
